//--- src/tec_pkg.sv
package tec_pkg;
   // Register byte addresses (index times four)
   localparam logic [7:0] COUNT_IDX = 8'h0d;
   localparam logic [7:0] CTRL_IDX = 8'h0e;
   localparam logic [7:0] IRQ_IDX = 8'h0b;
   localparam logic [9:0] COUNT_ADDR = {COUNT_IDX, 2'b00};
   localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
   localparam logic [9:0] IRQ_ADDR = {IRQ_IDX, 2'b00};
   // Control fields
   localparam int MODE_LSB = 6;
   localparam int EDGE_BIT = 3;
   localparam int EN_BIT = 4;
   localparam int PSC_LSB = 0;
   localparam logic [7:0] CTRL_MASK = 8'hdf;
   localparam logic [7:0] CTRL_RESET = 8'h08;
   // Interrupt control fields, counter and prescaler constants
   localparam int IRQ_EN_BIT = 0;
   localparam int IRQ_FLAG_BIT = 5;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [6:0] PSC_RESET = 7'h00;

   typedef enum logic [1:0]
   {
      MODE_UNUSED = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_TIMER = 2'b10,
      MODE_PULSE = 2'b11
   } tec_mode_t;

   typedef struct packed
   {
      tec_mode_t mode;
      logic rsvd;
      logic enable;
      logic edge_sel;
      logic [2:0] psc;
   } tec_ctrl_t;
endpackage : tec_pkg

//--- src/tec_timer.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - 8-bit up-counter clocked by pin edges or prescaled clock per mode
// - Divided output frequency is count clock over 2 times (256-N)
// - Counter location writes preload, reads live counter
// - Mode field bits 7:6: 01 event, 10 timer, 11 pulse, 00 unused
// - Event/timer count to FFh, reload from preload, set flag bit 5
// - Pulse mode counts from start edge until level returns, clears enable
// - After measurement hold result, ignore edges until enable set again
// - Pulse mode starts on an edge, not on an already active level
// - Overflow in pulse mode reloads and raises request too
// - Counting only while control bit 4 is set by software
// - Hardware clears enable only in pulse mode
// - Overflow produces a wake-up pulse ending halt
// - Clear interrupt enable blocks overflow interrupt in all modes
// - Write while disabled loads counter too; while enabled preload only
// - Count clock blocked during a counter read
// - Bits 2:0 divide system clock by two to the field value
// - Event mode bit 3: 1 falling edges, 0 rising edges
// - Pulse mode bit 3: 1 high pulse measured, 0 low pulse
// - Control bit 5 reads as zero
// - Timer mode uses prescaled clock, event mode uses pin edges
// - Divided output toggles once per overflow
module tec_timer
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and events
   input wire logic count_value_or_input_pin,
   output logic divided_freq_output,
   output logic irq,
   output logic wakeup
);

   tec_pkg::tec_ctrl_t ctrl_r;
   logic [7:0] preload_r;
   logic [7:0] count_r;
   logic [6:0] psc_r;
   logic overflow_irq_flag_r;
   logic overflow_irq_enable_r;
   logic pin_s1_r;
   logic pin_s2_r;
   logic pin_prev_r;
   logic pulse_active_r;
   logic pfd_r;
   logic irq_r;
   logic wake_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   logic access;
   logic addr_ok;
   logic wr_count;
   logic wr_ctrl;
   logic wr_irq;
   logic rd_count;
   logic rise;
   logic fall;
   logic psc_tick;
   logic tick;
   logic start_edge;
   logic stop_edge;
   logic overflow;
   logic pulse_done;

   function automatic logic psc_tap(input logic [6:0] cnt,
                                    input logic [2:0] sel);
      logic r;
      r = 1'b1;
      if (sel != 3'h0)
      begin
         r = &cnt[3'(sel - 3'h1) -: 1] && ((cnt & ((7'h01 << sel) - 7'h01))
             == ((7'h01 << sel) - 7'h01));
      end
      return r;
   endfunction : psc_tap

   // Register select on the word index of a byte address
   function automatic logic reg_hit(input logic [11:0] addr,
                                    input logic [7:0] idx);
      return addr[11:2] == {2'b00, idx};
   endfunction : reg_hit

   // Bus decode
   assign access = psel && penable && !pready_r;
   assign addr_ok = reg_hit(paddr, tec_pkg::COUNT_IDX)
                 || reg_hit(paddr, tec_pkg::CTRL_IDX)
                 || reg_hit(paddr, tec_pkg::IRQ_IDX);
   assign wr_count = access && pwrite
                  && reg_hit(paddr, tec_pkg::COUNT_IDX);
   assign wr_ctrl = access && pwrite
                 && reg_hit(paddr, tec_pkg::CTRL_IDX);
   assign wr_irq = access && pwrite
                && reg_hit(paddr, tec_pkg::IRQ_IDX);
   assign rd_count = psel && !pwrite
                  && reg_hit(paddr, tec_pkg::COUNT_IDX);

   // Edge detection
   assign rise = pin_s2_r && !pin_prev_r;
   assign fall = !pin_s2_r && pin_prev_r;
   // Prescaler tap: all low sel bits set means one tick per 2^sel
   assign psc_tick = psc_tap(psc_r, ctrl_r.psc);

   // Start and stop edges of the measured pulse
   assign start_edge = ctrl_r.edge_sel ? rise : fall;
   assign stop_edge = ctrl_r.edge_sel ? fall : rise;

   always_comb
   begin
      tick = 1'b0;
      unique case (ctrl_r.mode)
         tec_pkg::MODE_EVENT: tick = ctrl_r.edge_sel ? fall : rise;
         tec_pkg::MODE_TIMER: tick = psc_tick;
         tec_pkg::MODE_PULSE: tick = psc_tick && pulse_active_r;
         tec_pkg::MODE_UNUSED: tick = 1'b0;
      endcase
      tick = tick && ctrl_r.enable && !rd_count;
   end

   assign overflow = tick && (count_r == tec_pkg::COUNT_MAX);
   assign pulse_done = (ctrl_r.mode == tec_pkg::MODE_PULSE) && ctrl_r.enable
                    && pulse_active_r && stop_edge;

   // Input synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_prev_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= count_value_or_input_pin;
         pin_s2_r <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   // Prescaler
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         psc_r <= tec_pkg::PSC_RESET;
      else
         psc_r <= psc_r + 7'h01;
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= tec_pkg::CTRL_RESET;
      else if (wr_ctrl)
         ctrl_r <= pwdata[7:0] & tec_pkg::CTRL_MASK;
      else if (pulse_done)
         ctrl_r.enable <= 1'b0;
   end

   // Pulse measurement state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulse_active_r <= 1'b0;
      else if (!ctrl_r.enable || ctrl_r.mode != tec_pkg::MODE_PULSE
               || pulse_done)
         pulse_active_r <= 1'b0;
      else if (start_edge)
         pulse_active_r <= 1'b1;
   end

   // Preload and counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         preload_r <= tec_pkg::COUNT_RESET;
      else if (wr_count)
         preload_r <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= tec_pkg::COUNT_RESET;
      else if (wr_count && !ctrl_r.enable)
         count_r <= pwdata[7:0];
      else if (overflow)
         count_r <= preload_r;
      else if (tick)
         count_r <= count_r + 8'h01;
   end

   // Interrupt control, flag and enable; set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         overflow_irq_flag_r <= 1'b0;
         overflow_irq_enable_r <= 1'b0;
      end
      else
      begin
         if (wr_irq)
            overflow_irq_enable_r <= pwdata[tec_pkg::IRQ_EN_BIT];
         if (overflow)
            overflow_irq_flag_r <= 1'b1;
         else if (wr_irq)
            overflow_irq_flag_r <= pwdata[tec_pkg::IRQ_FLAG_BIT];
      end
   end

   // Outputs from flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pfd_r <= 1'b0;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         if (overflow)
            pfd_r <= !pfd_r;
         irq_r <= overflow_irq_flag_r && overflow_irq_enable_r;
         wake_r <= overflow;
      end
   end

   // APB answer: one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= access;
         pslverr_r <= access && !addr_ok;
         prdata_r <= 32'h0000_0000;
         if (access && !pwrite)
         begin
            if (reg_hit(paddr, tec_pkg::COUNT_IDX))
               prdata_r <= {24'h00_0000, count_r};
            else if (reg_hit(paddr, tec_pkg::CTRL_IDX))
               prdata_r <= {24'h00_0000, ctrl_r & tec_pkg::CTRL_MASK};
            else if (reg_hit(paddr, tec_pkg::IRQ_IDX))
               prdata_r <= {24'h00_0000, 2'b00, overflow_irq_flag_r,
                            4'h0, overflow_irq_enable_r};
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign divided_freq_output = pfd_r;
   assign irq = irq_r;
   assign wakeup = wake_r;

   // Checks
   a_ovf_reload: assert property (@(posedge pclk) disable iff (!presetn)
      overflow && !(wr_count && !ctrl_r.enable) |=> count_r == $past(preload_r))
      else $error("no reload on overflow");
   a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
      overflow |=> overflow_irq_flag_r)
      else $error("flag not set");
   a_pfd_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      overflow |=> divided_freq_output != $past(divided_freq_output))
      else $error("pfd not toggled");
   a_no_count_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.enable && !wr_count |=> $stable(count_r))
      else $error("count while disabled");
   a_read_block: assert property (@(posedge pclk) disable iff (!presetn)
      rd_count && !wr_count |=> $stable(count_r))
      else $error("count during read");
   a_en_hw_clear: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ctrl_r.enable) && !$past(wr_ctrl) |->
      $past(ctrl_r.mode) == tec_pkg::MODE_PULSE)
      else $error("enable cleared outside pulse mode");
   a_bit5_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.rsvd)
      else $error("reserved bit set");
   a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !overflow_irq_enable_r |=> !irq)
      else $error("irq while disabled");
   a_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      overflow |=> wakeup)
      else $error("no wakeup");
   a_load_off: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count && !ctrl_r.enable |=> count_r == $past(pwdata[7:0]))
      else $error("counter not loaded");

   a_event_count: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.mode == tec_pkg::MODE_EVENT && ctrl_r.enable && !rd_count
      && (ctrl_r.edge_sel ? fall : rise) && !wr_count
      && count_r != tec_pkg::COUNT_MAX |=> count_r == $past(count_r) + 8'h01)
      else $error("event edge not counted");

   a_timer_tick: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.mode == tec_pkg::MODE_TIMER && ctrl_r.enable && !rd_count
      && psc_tick && !wr_count
      && count_r != tec_pkg::COUNT_MAX |=> count_r == $past(count_r) + 8'h01)
      else $error("timer tick not counted");

   a_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
      tick && count_r != tec_pkg::COUNT_MAX && !(wr_count && !ctrl_r.enable)
      |=> count_r == $past(count_r) + 8'h01)
      else $error("count not incremented");

   a_unused_mode: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.mode == tec_pkg::MODE_UNUSED && !wr_count |=> $stable(count_r))
      else $error("count in unused mode");

   a_pulse_idle: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.mode == tec_pkg::MODE_PULSE && !pulse_active_r && !wr_count
      |=> $stable(count_r))
      else $error("count before start edge");

   a_pulse_stop: assert property (@(posedge pclk) disable iff (!presetn)
      pulse_done && !wr_ctrl |=> !ctrl_r.enable)
      else $error("enable kept after measurement");

   a_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.mode == tec_pkg::MODE_PULSE && !ctrl_r.enable
      |=> !pulse_active_r)
      else $error("measurement restarted");

   a_en_kept: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.mode != tec_pkg::MODE_PULSE && !wr_ctrl
      |=> ctrl_r.enable == $past(ctrl_r.enable))
      else $error("enable changed by hardware");

   a_preload_only: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count && ctrl_r.enable && !tick |=> count_r == $past(count_r))
      else $error("counter loaded while enabled");

   a_preload_wr: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count |=> preload_r == $past(pwdata[7:0]))
      else $error("preload not written");

   a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
      overflow_irq_flag_r && overflow_irq_enable_r |=> irq)
      else $error("irq missing");

   a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !overflow_irq_flag_r |=> !irq)
      else $error("irq without flag");

   a_psc_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.psc == 3'h0 |-> psc_tick)
      else $error("undivided clock skipped");

   a_pfd_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !overflow |=> $stable(divided_freq_output))
      else $error("pfd toggled without overflow");

   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready longer than one cycle");

   a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");

   a_rd_upper: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
endmodule : tec_timer

`default_nettype wire

//--- test/tec_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module tec_pin_model
(
   // Clock
   input wire logic pclk,
   // Event pin
   output logic pin
);
   initial pin = 1'b0;

   // Hold a level for n clocks
   task automatic level(input logic v, input int n);
      pin <= v;
      repeat (n) @(posedge pclk);
   endtask : level

   // One pulse away from the idle level
   task automatic pulse(input int n);
      level(~pin, n);
      level(~pin, n);
   endtask : pulse
endmodule : tec_pin_model

`default_nettype wire

//--- test/tec_timer_test.sv
`timescale 1ns/100ps
`default_nettype none

module tec_timer_test;
   localparam logic [9:0] K = tec_pkg::COUNT_ADDR;
   localparam logic [9:0] C = tec_pkg::CTRL_ADDR;
   localparam logic [9:0] I = tec_pkg::IRQ_ADDR;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin;
   logic freq_out;
   logic irq;
   logic wakeup;
   logic [7:0] rd;
   int cyc = 0;
   int num_errors = 0;
   int num_checks = 0;

   always #12.5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   tec_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_value_or_input_pin(pin), .divided_freq_output(freq_out),
      .irq(irq), .wakeup(wakeup));
   tec_pin_model i_pin (.pclk(pclk), .pin(pin));

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [9:0] a,
                      input logic [7:0] d, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, a};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) num_errors++;
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic e;
      apb(1'b1, a, d, e);
   endtask : wr

   task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
      logic e;
      apb(1'b0, a, 8'h00, e);
      chk(rd, exp);
   endtask : rdchk

   task automatic wait_wake;
      int n;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (wakeup !== 1'b1 && n < 400);
      if (wakeup !== 1'b1) num_errors++;
   endtask : wait_wake

   task automatic t_reset;
      logic e;
      rdchk(C, 8'h08);
      rdchk(K, 8'h00);
      wr(C, 8'hff);
      rdchk(C, 8'hdf);
      wr(C, 8'h08);
      apb(1'b0, 10'h3fc, 8'h00, e);
      chk(e, 1'b1);
      $display("reset test done");
   endtask : t_reset

   task automatic t_timer;
      wr(K, 8'hc0);
      rdchk(K, 8'hc0);
      wr(I, 8'h01);
      wr(C, 8'h90);
      wait_wake();
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      chk(freq_out, 1'b1);
      rdchk(I, 8'h21);
      rdchk(C, 8'h90);
      wr(I, 8'h00);
      wait_wake();
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      chk(freq_out, 1'b0);
      rdchk(I, 8'h20);
      wr(I, 8'h00);
      wr(C, 8'h08);
      $display("timer test done");
   endtask : t_timer

   task automatic t_psc;
      int t0;
      for (int p = 0; p < 8; p++)
      begin
         wr(C, 8'h08);
         wr(K, 8'hfe);
         wr(C, 8'h90 | 8'(p));
         wait_wake();
         t0 = cyc;
         wait_wake();
         chk(16'(cyc - t0), 16'(2 << p));
      end
      wr(C, 8'h08);
      $display("prescale test done");
   endtask : t_psc

   task automatic t_event;
      wr(K, 8'h10);
      wr(C, 8'h50);
      repeat (3) i_pin.pulse(4);
      repeat (6) @(posedge pclk);
      rdchk(K, 8'h13);
      wr(C, 8'h58);
      i_pin.level(1'b1, 6);
      rdchk(K, 8'h13);
      i_pin.level(1'b0, 6);
      rdchk(K, 8'h14);
      wr(C, 8'h48);
      i_pin.pulse(4);
      repeat (6) @(posedge pclk);
      rdchk(K, 8'h14);
      $display("event test done");
   endtask : t_event

   task automatic t_pulse;
      logic [7:0] m;
      wr(C, 8'h08);
      wr(K, 8'h00);
      i_pin.level(1'b1, 2);
      wr(C, 8'hd8);
      i_pin.level(1'b1, 10);
      i_pin.level(1'b0, 6);
      i_pin.level(1'b1, 20);
      i_pin.level(1'b0, 6);
      rdchk(C, 8'hc8);
      rdchk(K, 8'h14);
      m = rd;
      chk(rd >= 8'h13 && rd <= 8'h15, 1'b1);
      i_pin.pulse(8);
      repeat (6) @(posedge pclk);
      rdchk(K, m);
      $display("pulse test done");
   endtask : t_pulse

   initial
   begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_timer();
      t_psc();
      t_event();
      t_pulse();
      tally_and_finish();
   end
endmodule : tec_timer_test

`default_nettype wire
